// ==== common/cfi_pkg.sv ====
package cfi_pkg;

   // Flag positions in the cpu flag register
   localparam int FL_C = 0;
   localparam int FL_Z = 1;
   localparam int FL_I = 2;
   localparam int FL_D = 3;
   localparam int FL_B = 4;
   localparam int FL_T = 5;
   localparam int FL_V = 6;
   localparam int FL_N = 7;

   localparam logic [7:0] FLAGS_RST  = 8'h04;
   localparam logic [7:0] SP_RST     = 8'hFF;
   localparam logic [7:0] STACK_PAGE = 8'h01;
   localparam logic [7:0] ZERO_PAGE  = 8'h00;
   localparam logic [2:0] CFG_RST    = 3'h0;
   localparam logic [3:0] DIV_SLOW   = 4'hF;
   localparam logic [4:0] BCD_MAX    = 5'h09;
   localparam logic [4:0] BCD_ADJ    = 5'h06;

   // Register indexes
   localparam logic [3:0] REG_CMD     = 4'h0;
   localparam logic [3:0] REG_OPND    = 4'h1;
   localparam logic [3:0] REG_ACC     = 4'h2;
   localparam logic [3:0] REG_X       = 4'h3;
   localparam logic [3:0] REG_HI      = 4'h4;
   localparam logic [3:0] REG_SP      = 4'h5;
   localparam logic [3:0] REG_FLAGS   = 4'h6;
   localparam logic [3:0] REG_TADDR_L = 4'h7;
   localparam logic [3:0] REG_TADDR_H = 4'h8;
   localparam logic [3:0] REG_CLKCFG  = 4'h9;
   localparam logic [3:0] REG_STATUS  = 4'hA;

   // Instruction cycles per class
   localparam logic [4:0] CYC_REG  = 5'h02;
   localparam logic [4:0] CYC_PUSH = 5'h03;
   localparam logic [4:0] CYC_PULL = 5'h04;
   localparam logic [4:0] CYC_RMW  = 5'h05;
   localparam logic [4:0] CYC_BRK  = 5'h07;
   localparam logic [4:0] CYC_MULT = 5'h08;
   localparam logic [4:0] CYC_QUOT = 5'h10;

   localparam int         NUM_SRC = 8;
   localparam logic [3:0] VEC_BRK = 4'h8;

   typedef enum logic [4:0] {
      OP_NOP   = 5'h00, OP_ADD   = 5'h01, OP_SUB   = 5'h02, OP_AND   = 5'h03,
      OP_XOR   = 5'h04, OP_OR    = 5'h05, OP_SHL   = 5'h06, OP_SHR   = 5'h07,
      OP_ROTL  = 5'h08, OP_ROTR  = 5'h09, OP_NIB   = 5'h0A, OP_MINUS = 5'h0B,
      OP_PLUS  = 5'h0C, OP_INV   = 5'h0D, OP_BCLR  = 5'h0E, OP_BSET  = 5'h0F,
      OP_PUSHF = 5'h10, OP_PULLF = 5'h11, OP_MULT  = 5'h12, OP_QUOT  = 5'h13,
      OP_BREAK = 5'h14, OP_CSET  = 5'h15, OP_CCLR  = 5'h16, OP_DSET  = 5'h17,
      OP_DCLR  = 5'h18, OP_TSET  = 5'h19, OP_TCLR  = 5'h1A, OP_ISET  = 5'h1B,
      OP_ICLR  = 5'h1C
   } cfi_op_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_FETCH  = 3'b001,
      ST_CAPT   = 3'b010,
      ST_MODIFY = 3'b011,
      ST_STORE  = 3'b100,
      ST_PAD    = 3'b101
   } cfi_state_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cfi_reg_req_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } cfi_mem_req_t;

   function automatic logic cfi_is_alu(input cfi_op_t op);
      return op == OP_ADD || op == OP_SUB || op == OP_AND || op == OP_XOR || op == OP_OR;
   endfunction

   function automatic logic cfi_is_rmw(input cfi_op_t op, input logic t);
      return (op >= OP_SHL && op <= OP_BSET) || (t && cfi_is_alu(op));
   endfunction

   function automatic logic [4:0] cfi_op_cycles(input cfi_op_t op, input logic t);
      logic [4:0] n;
      n = CYC_REG;
      case (op)
         OP_PUSHF: n = CYC_PUSH;
         OP_PULLF: n = CYC_PULL;
         OP_BREAK: n = CYC_BRK;
         OP_MULT:  n = CYC_MULT;
         OP_QUOT:  n = CYC_QUOT;
         default:  n = cfi_is_rmw(op, t) ? CYC_RMW : CYC_REG;
      endcase
      return n;
   endfunction

endpackage

// ==== rtl/cfi_bcd_alu.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfi_bcd_alu
   import cfi_pkg::*;
(
   // Operands
   input  wire logic [7:0] a,
   input  wire logic [7:0] b,
   input  wire logic       cin,
   // Mode
   input  wire logic       dec,
   input  wire logic       sub,
   // Result
   output var  logic [7:0] res,
   output var  logic       cout,
   output var  logic       ovf
);

   logic [8:0] bsum;
   logic [7:0] bb;
   logic [4:0] lo, hi;
   logic       c1;

   always_comb begin
      bb   = sub ? ~b : b;
      bsum = {1'b0, a} + {1'b0, bb} + {8'h00, cin}; // RULE_18
      // Overflow stays binary in decimal mode; software may not use it
      ovf  = (a[7] == bb[7]) && (bsum[7] != a[7]); // RULE_06
      res  = bsum[7:0];
      cout = bsum[8];
      lo   = 5'h00;
      hi   = 5'h00;
      c1   = 1'b0;
      if (dec && !sub) begin // RULE_04
         lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin}; // RULE_18
         c1 = lo > BCD_MAX;
         if (c1) lo = lo + BCD_ADJ;
         hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, c1};
         cout = hi > BCD_MAX; // RULE_07
         if (cout) hi = hi + BCD_ADJ;
         res = {hi[3:0], lo[3:0]};
      end else if (dec) begin // RULE_04
         lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, !cin}; // RULE_18
         c1 = lo[4];
         if (c1) lo = lo - BCD_ADJ;
         hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, c1};
         cout = !hi[4]; // RULE_07
         if (hi[4]) hi = hi - BCD_ADJ;
         res = {hi[3:0], lo[3:0]};
      end
   end

endmodule
`default_nettype wire

// ==== rtl/cfi_core.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01: Reset sets the interrupt disable flag; other flags unspecified.
// RULE_02: Software initialises index x mode and decimal mode flags after reset.
// RULE_03: Flags push stores flags at stack pointer plus one; pull restores them.
// RULE_04: Decimal mode adjusts only add with carry and subtract with borrow.
// RULE_05: Software inserts one instruction before carry or decimal flag ops after decimal math.
// RULE_06: Negative, overflow and zero flags are undefined after decimal math.
// RULE_07: Decimal carry sets carry flag; decimal borrow clears it.
// RULE_08: Software presets carry before decimal add or subtract it will test.
// RULE_09: Product and quotient ignore index x mode and decimal mode.
// RULE_10: Product and quotient leave every flag unchanged.
// RULE_11: Software never puts an indirect jump pointer at a page end.
// RULE_12: Software break vectors to the highest pending enabled source.
// RULE_13: Read-modify-write reads a byte, modifies it, writes it back there.
// RULE_14: Bit, shift, rotate, nibble, minus, plus and invert use read-modify-write.
// RULE_15: With index x mode set, arithmetic and logic ops use read-modify-write.
// RULE_16: Software keeps read-modify-write away from read-invalid addresses.
// RULE_17: Each instruction takes its listed count of system clock cycles.
// RULE_18: Incoming carry is the low digit's carry-in or inverted borrow-in.
module cfi_core
   import cfi_pkg::*;
(
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               resetn,
   // Register port
   input  wire cfi_reg_req_t       reg_req,
   output var  logic [7:0]         reg_rdata,
   // Memory master, read data valid the cycle after the strobe
   output var  cfi_mem_req_t       mem_req,
   input  wire logic [7:0]         mem_rdata,
   // Interrupt sources, same clock
   input  wire logic [NUM_SRC-1:0] irq_req,
   input  wire logic [NUM_SRC-1:0] irq_en,
   // Status
   output var  logic               busy,
   output var  logic               done,
   output var  logic [3:0]         brk_vec,
   output var  logic               brk_take
);

   logic [7:0]   flags_q, flags_d, acc_q, acc_d, x_q, x_d, hi_q, hi_d;
   logic [7:0]   sp_q, sp_d, opnd_q, opnd_d, mdata_q, mdata_d, rdata_q, rdata_d;
   logic [15:0]  taddr_q, taddr_d;
   logic [2:0]   cfg_q, cfg_d;
   logic [4:0]   cyc_q, cyc_d, need_q, need_d;
   logic [3:0]   vec_q, vec_d;
   cfi_op_t      op_q, op_d;
   cfi_state_t   state_q, state_d;
   cfi_mem_req_t mem_q, mem_d;
   logic         rd_ack_q, busy_q, busy_d, done_q, done_d, vtake_q, vtake_d;
   logic         phi_en, t_arith, rmw, alu_c, alu_v, co, nz;
   logic [7:0]   mval, alu_a, alu_res, r, pend;

   function automatic logic [3:0] pick_src(input logic [NUM_SRC-1:0] p);
      logic [3:0] v;
      v = VEC_BRK;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (p[i]) v = 4'(i);
      end
      return v;
   endfunction

   cfi_phi_div u_div (
      .clock  (clock),
      .resetn (resetn),
      .sel    (cfg_q),
      .phi_en (phi_en)
   );

   cfi_bcd_alu u_alu (
      .a    (alu_a),
      .b    (opnd_q),
      .cin  (flags_q[FL_C]),
      .dec  (flags_q[FL_D]),
      .sub  (op_q == OP_SUB),
      .res  (alu_res),
      .cout (alu_c),
      .ovf  (alu_v)
   );

   assign t_arith = flags_q[FL_T] && cfi_is_alu(op_q); // RULE_15
   assign rmw     = cfi_is_rmw(op_q, flags_q[FL_T]); // RULE_14
   assign mval    = rd_ack_q ? mem_rdata : mdata_q;
   assign alu_a   = t_arith ? mval : acc_q;
   assign pend    = irq_req & irq_en;

   always_comb begin
      flags_d = flags_q;
      acc_d   = acc_q;
      x_d     = x_q;
      hi_d    = hi_q;
      sp_d    = sp_q;
      opnd_d  = opnd_q;
      taddr_d = taddr_q;
      cfg_d   = cfg_q;
      op_d    = op_q;
      state_d = state_q;
      cyc_d   = cyc_q;
      need_d  = need_q;
      vec_d   = vec_q;
      mdata_d = mval;
      busy_d  = busy_q;
      done_d  = 1'b0;
      vtake_d = 1'b0;
      rdata_d = 8'h00;
      mem_d    = mem_q;
      mem_d.rd = 1'b0;
      mem_d.wr = 1'b0;
      r  = 8'h00;
      co = flags_q[FL_C];
      nz = 1'b0;

      if (reg_req.rd) begin
         if (reg_req.addr == REG_CMD) rdata_d = {3'h0, op_q};
         else if (reg_req.addr == REG_OPND) rdata_d = opnd_q;
         else if (reg_req.addr == REG_ACC) rdata_d = acc_q;
         else if (reg_req.addr == REG_X) rdata_d = x_q;
         else if (reg_req.addr == REG_HI) rdata_d = hi_q;
         else if (reg_req.addr == REG_SP) rdata_d = sp_q;
         else if (reg_req.addr == REG_FLAGS) rdata_d = flags_q;
         else if (reg_req.addr == REG_TADDR_L) rdata_d = taddr_q[7:0];
         else if (reg_req.addr == REG_TADDR_H) rdata_d = taddr_q[15:8];
         else if (reg_req.addr == REG_CLKCFG) rdata_d = {5'h00, cfg_q};
         else if (reg_req.addr == REG_STATUS) rdata_d = {3'h0, busy_q, vec_q};
      end

      // Core state belongs to the sequencer while busy; writes other than REG_CLKCFG then are dropped
      if (reg_req.wr) begin
         if (reg_req.addr == REG_CLKCFG) cfg_d = reg_req.wdata[2:0]; // RULE_17
         else if (state_q == ST_IDLE) begin
            if (reg_req.addr == REG_CMD) begin
               op_d   = cfi_op_t'(reg_req.wdata[4:0]);
               need_d = cfi_op_cycles(op_d, flags_q[FL_T]); // RULE_17
               cyc_d  = 5'h00;
               busy_d = 1'b1;
               if (op_d == OP_PUSHF || op_d == OP_BREAK) state_d = ST_STORE;
               else if (op_d == OP_PULLF || cfi_is_rmw(op_d, flags_q[FL_T])) state_d = ST_FETCH;
               else state_d = ST_MODIFY;
            end
            else if (reg_req.addr == REG_OPND) opnd_d = reg_req.wdata;
            else if (reg_req.addr == REG_ACC) acc_d = reg_req.wdata;
            else if (reg_req.addr == REG_X) x_d = reg_req.wdata;
            else if (reg_req.addr == REG_HI) hi_d = reg_req.wdata;
            else if (reg_req.addr == REG_SP) sp_d = reg_req.wdata;
            else if (reg_req.addr == REG_FLAGS) flags_d = reg_req.wdata;
            else if (reg_req.addr == REG_TADDR_L) taddr_d[7:0] = reg_req.wdata;
            else if (reg_req.addr == REG_TADDR_H) taddr_d[15:8] = reg_req.wdata;
         end
      end

      if (phi_en && state_q != ST_IDLE) begin
         cyc_d = cyc_q + 5'h01;
         case (state_q)
            ST_FETCH: begin
               mem_d.rd = 1'b1;
               if (op_q == OP_PULLF) begin
                  sp_d       = sp_q + 8'h01;
                  mem_d.addr = {STACK_PAGE, sp_d}; // RULE_03
               end
               else if (t_arith) mem_d.addr = {ZERO_PAGE, x_q}; // RULE_15
               else mem_d.addr = taddr_q; // RULE_13
               state_d = ST_CAPT;
            end
            ST_CAPT: state_d = ST_MODIFY;
            ST_MODIFY: begin
               state_d = rmw ? ST_STORE : ST_PAD;
               case (op_q)
                  OP_ADD, OP_SUB: begin
                     r  = alu_res;
                     co = alu_c; // RULE_07
                     nz = 1'b1; // RULE_06
                     flags_d[FL_V] = alu_v;
                  end
                  OP_AND: begin
                     r  = alu_a & opnd_q;
                     nz = 1'b1;
                  end
                  OP_XOR: begin
                     r  = alu_a ^ opnd_q;
                     nz = 1'b1;
                  end
                  OP_OR: begin
                     r  = alu_a | opnd_q;
                     nz = 1'b1;
                  end
                  OP_SHL: begin
                     {co, r} = {mval, 1'b0};
                     nz      = 1'b1;
                  end
                  OP_SHR: begin
                     {r, co} = {1'b0, mval};
                     nz      = 1'b1;
                  end
                  OP_ROTL: begin
                     {co, r} = {mval, flags_q[FL_C]};
                     nz      = 1'b1;
                  end
                  OP_ROTR: begin
                     {r, co} = {flags_q[FL_C], mval};
                     nz      = 1'b1;
                  end
                  OP_NIB: r = {mval[3:0], mval[7:4]};
                  OP_MINUS: begin
                     r  = mval - 8'h01;
                     nz = 1'b1;
                  end
                  OP_PLUS: begin
                     r  = mval + 8'h01;
                     nz = 1'b1;
                  end
                  OP_INV: begin
                     r  = ~mval;
                     nz = 1'b1;
                  end
                  OP_BCLR: r = mval & ~(8'h01 << opnd_q[2:0]);
                  OP_BSET: r = mval | (8'h01 << opnd_q[2:0]);
                  // Flags and mode bits are never consulted here
                  OP_MULT: {hi_d, acc_d} = acc_q * opnd_q; // RULE_09 RULE_10
                  OP_QUOT: begin
                     // Zero divisor leaves both halves untouched
                     if (opnd_q != 8'h00) begin // RULE_09 RULE_10
                        acc_d = 8'({hi_q, acc_q} / {8'h00, opnd_q});
                        hi_d  = 8'({hi_q, acc_q} % {8'h00, opnd_q});
                     end
                  end
                  OP_CSET: co = 1'b1;
                  OP_CCLR: co = 1'b0;
                  OP_DSET: flags_d[FL_D] = 1'b1;
                  OP_DCLR: flags_d[FL_D] = 1'b0;
                  OP_TSET: flags_d[FL_T] = 1'b1;
                  OP_TCLR: flags_d[FL_T] = 1'b0;
                  OP_ISET: flags_d[FL_I] = 1'b1;
                  OP_ICLR: flags_d[FL_I] = 1'b0;
                  default: r = 8'h00;
               endcase
               flags_d[FL_C] = co;
               if (nz) begin
                  flags_d[FL_N] = r[7];
                  flags_d[FL_Z] = (r == 8'h00);
               end
               if (op_q == OP_PULLF) flags_d = mval; // RULE_03
               if (rmw) mdata_d = r; // RULE_13
               else if (cfi_is_alu(op_q)) acc_d = r;
            end
            ST_STORE: begin
               mem_d.wr    = 1'b1;
               mem_d.wdata = mdata_q; // RULE_13
               if (op_q == OP_PUSHF || op_q == OP_BREAK) begin
                  mem_d.addr  = {STACK_PAGE, sp_q}; // RULE_03
                  mem_d.wdata = flags_q;
                  sp_d        = sp_q - 8'h01;
                  if (op_q == OP_BREAK) begin
                     mem_d.wdata[FL_B] = 1'b1;
                     flags_d[FL_I]     = 1'b1;
                     vec_d             = pick_src(pend); // RULE_12
                     vtake_d           = 1'b1;
                  end
               end
               state_d = ST_PAD;
            end
            ST_PAD: begin
               if (cyc_d >= need_q) begin // RULE_17
                  state_d = ST_IDLE;
                  busy_d  = 1'b0;
                  done_d  = 1'b1;
               end
            end
            default: state_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         flags_q  <= FLAGS_RST; // RULE_01
         acc_q    <= 8'h00;
         x_q      <= 8'h00;
         hi_q     <= 8'h00;
         sp_q     <= SP_RST;
         opnd_q   <= 8'h00;
         taddr_q  <= 16'h0000;
         cfg_q    <= CFG_RST;
         op_q     <= OP_NOP;
         state_q  <= ST_IDLE;
         cyc_q    <= 5'h00;
         need_q   <= 5'h00;
         vec_q    <= VEC_BRK;
         mdata_q  <= 8'h00;
         rdata_q  <= 8'h00;
         mem_q    <= '0;
         rd_ack_q <= 1'b0;
         busy_q   <= 1'b0;
         done_q   <= 1'b0;
         vtake_q  <= 1'b0;
      end else begin
         flags_q  <= flags_d;
         acc_q    <= acc_d;
         x_q      <= x_d;
         hi_q     <= hi_d;
         sp_q     <= sp_d;
         opnd_q   <= opnd_d;
         taddr_q  <= taddr_d;
         cfg_q    <= cfg_d;
         op_q     <= op_d;
         state_q  <= state_d;
         cyc_q    <= cyc_d;
         need_q   <= need_d;
         vec_q    <= vec_d;
         mdata_q  <= mdata_d;
         rdata_q  <= rdata_d;
         mem_q    <= mem_d;
         rd_ack_q <= mem_q.rd;
         busy_q   <= busy_d;
         done_q   <= done_d;
         vtake_q  <= vtake_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign mem_req   = mem_q;
   assign busy      = busy_q;
   assign done      = done_q;
   assign brk_vec   = vec_q;
   assign brk_take  = vtake_q;

   // Checking helpers
   logic [4:0]   chk_cnt_q;
   logic [15:0]  rd_addr_q;
   logic [7:0]   pend_q;

   function automatic int bcd_val(input logic [7:0] v);
      return 10 * int'(v[7:4]) + int'(v[3:0]);
   endfunction

   function automatic logic bcd_ok(input logic [7:0] v);
      return v[7:4] <= BCD_MAX[3:0] && v[3:0] <= BCD_MAX[3:0];
   endfunction

   always_ff @(posedge clock) begin
      if (!resetn) begin
         chk_cnt_q <= 5'h00;
         rd_addr_q <= 16'h0000;
         pend_q    <= 8'h00;
      end else begin
         pend_q <= pend;
         if (mem_req.rd) rd_addr_q <= mem_req.addr;
         if (reg_req.wr && reg_req.addr == REG_CMD && state_q == ST_IDLE) chk_cnt_q <= 5'h00;
         else if (phi_en && state_q != ST_IDLE) chk_cnt_q <= chk_cnt_q + 5'h01;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence pull_rd_s;
      mem_req.rd && op_q == OP_PULLF;
   endsequence

   sequence rmw_rd_s;
      mem_req.rd && rmw;
   endsequence

   property pull_load_p;
      logic [7:0] v;
      (pull_rd_s ##1 (1'b1, v = mem_rdata)) |-> ##[1:100] (done_q && flags_q == v);
   endproperty

   reset_iflag_a: assert property ($rose(resetn) |-> flags_q[FL_I]) // RULE_01
      else $error("interrupt disable flag not set after reset");
   push_store_a: assert property ((phi_en && state_q == ST_STORE && op_q == OP_PUSHF) // RULE_03
      |=> mem_req.wr && mem_req.addr == {STACK_PAGE, sp_q + 8'h01}
          && mem_req.wdata == flags_q)
      else $error("flags push not readable at stack pointer plus one");
   pull_load_a: assert property (pull_load_p) // RULE_03
      else $error("flags pull did not restore stacked byte");
   dec_carry_a: assert property ((phi_en && state_q == ST_MODIFY && op_q == OP_ADD // RULE_07
      && flags_q[FL_D] && !flags_q[FL_T] && bcd_ok(alu_a) && bcd_ok(opnd_q))
      |=> flags_q[FL_C] == ((bcd_val($past(alu_a)) + bcd_val($past(opnd_q))
          + int'($past(flags_q[FL_C]))) > 99))
      else $error("decimal carry flag wrong");
   muldiv_flags_a: assert property ((busy_q && (op_q == OP_MULT || op_q == OP_QUOT)) // RULE_10
      |=> $stable(flags_q))
      else $error("product or quotient changed a flag");
   rmw_same_addr_a: assert property ((mem_req.wr && rmw) |-> mem_req.addr == rd_addr_q) // RULE_13
      else $error("read-modify-write wrote another address");
   rmw_order_a: assert property (rmw_rd_s |-> ##[2:100] (mem_req.wr && done_q == 1'b0)) // RULE_14
      else $error("read-modify-write read not followed by write back");
   instr_time_a: assert property (done_q |-> chk_cnt_q == need_q && !busy_q) // RULE_17
      else $error("instruction cycle count wrong");
   break_vec_a: assert property (brk_take |-> flags_q[FL_I] // RULE_12
      && ((brk_vec == VEC_BRK) ? (pend_q == 8'h00)
          : (pend_q[brk_vec[2:0]] && (pend_q & ((8'h01 << brk_vec[2:0]) - 8'h01)) == 8'h00)))
      else $error("break vector not highest pending source");

endmodule
`default_nettype wire

// ==== rtl/cfi_phi_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfi_phi_div
   import cfi_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       resetn,
   // {source select, division ratio select}
   input  wire logic [2:0] sel,
   output var  logic       phi_en
);

   logic [3:0] cnt_q, cnt_d, lim;
   logic       en_q, en_d;

   // Ratio change takes effect at once: the running count is compared with the new limit
   always_comb begin
      lim  = sel[2] ? DIV_SLOW : (4'h1 << sel[1:0]) - 4'h1;
      cnt_d = cnt_q + 4'h1;
      en_d  = 1'b0;
      if (cnt_q >= lim) begin
         cnt_d = 4'h0;
         en_d  = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         cnt_q <= 4'h0;
         en_q  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         en_q  <= en_d;
      end
   end

   assign phi_en = en_q;

endmodule
`default_nettype wire

// ==== testbench/cfi_core_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfi_core_tb_top
   import cfi_pkg::*;
();
   logic               clock = 1'h0;
   logic               resetn = 1'h0;
   cfi_reg_req_t       rq = '0;
   cfi_mem_req_t       mq;
   logic [7:0]         mem_rdata = 8'h00, rdata, mv = 8'h00, wd = 8'h00, a, b, f, v;
   logic [NUM_SRC-1:0] irq_req = '0, irq_en = '0;
   logic               busy, done, tk;
   logic [3:0]         vec;
   logic [15:0]        ra = '0, wa = '0, nt = '0, t, p;
   logic [8:0]         e;
   logic [31:0]        rn = 32'h0AD9;
   int                 failures = 0, cmp_count = 0, rt = 1;
   always #5 clock = ~clock;
   cfi_core dut (.clock(clock), .resetn(resetn), .reg_req(rq), .reg_rdata(rdata),
      .mem_req(mq), .mem_rdata(mem_rdata), .irq_req(irq_req), .irq_en(irq_en),
      .busy(busy), .done(done), .brk_vec(vec), .brk_take(tk));
   // Idle data bus toggles so a stale byte never passes for an answer
   always @(posedge clock) begin
      mem_rdata <= mq.rd ? mv : ~mem_rdata;
      if (tk) nt <= nt + 16'h0001;
      if (mq.rd) ra <= mq.addr;
      if (mq.wr) begin
         wa <= mq.addr;
         wd <= mq.wdata;
      end
   end
   function automatic logic [31:0] nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Valid BCD operands only; carry is the inverted borrow on subtract
   function automatic logic [8:0] bcd(input logic [7:0] x, y, input logic c, s);
      int  r;
      int  q;
      logic k;
      r = x[7:4] * 10 + x[3:0];
      q = y[7:4] * 10 + y[3:0];
      r = s ? r - q - int'(!c) : r + q + int'(c);
      k = s ? r >= 0 : r > 99;
      r = (r + 100) % 100;
      return {k, 4'(r / 10), 4'(r % 10)};
   endfunction
   // Carry is always clear going in
   function automatic logic [7:0] rmw(input logic [4:0] o, input logic [7:0] x, y);
      case (o)
         5'h01: return x + y;
         5'h02: return x - y - 8'h01;
         5'h03: return x & y;
         5'h04: return x ^ y;
         5'h05: return x | y;
         5'h06: return x << 1;
         5'h07: return x >> 1;
         5'h08: return {x[6:0], 1'h0};
         5'h09: return {1'h0, x[7:1]};
         5'h0A: return {x[3:0], x[7:4]};
         5'h0B: return x - 8'h01;
         5'h0C: return x + 8'h01;
         5'h0D: return ~x;
         5'h0E: return x & ~(8'h01 << y[2:0]);
         default: return x | (8'h01 << y[2:0]);
      endcase
   endfunction
   function automatic logic [3:0] low(input logic [7:0] m);
      for (int k = 0; k < NUM_SRC; k++) begin
         if (m[k]) return 4'(k);
      end
      return VEC_BRK;
   endfunction
   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, x);
      cmp_count++;
      if (g !== x) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [7:0] d);
      @(posedge clock);
      rq <= '{addr: ad, wdata: d, wr: 1'h1, rd: 1'h0};
      @(posedge clock);
      rq.wr <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] ad, output logic [7:0] d);
      @(posedge clock);
      rq <= '{addr: ad, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
      @(posedge clock);
      rq.rd <= 1'h0;
      #1 d = rdata;
   endtask
   task automatic run(input logic [4:0] op, input logic [4:0] n);
      int c;
      wr(REG_CMD, {3'h0, op});
      for (c = 1; c < 40; c++) begin
         #1;
         if (done === 1'h1) break;
         @(posedge clock);
      end
      if (rt == 1) chk(16'(c), 16'(n) + 16'h0001);
      else chk(16'(c > rt * (n - 1) + 1 && c <= rt * n + 1), 16'h0001);
      chk(16'({busy, done}), 16'h0001);
      if (c == 40) summarize;
   endtask
   initial begin
      repeat (4) @(posedge clock);
      resetn <= 1'h1;
      rd(REG_FLAGS, v);
      chk(v & 8'h04, 8'h04);
      rn = nx(rn);
      f = rn[7:0] & 8'hEF;
      wr(REG_FLAGS, f);
      run(OP_PUSHF, CYC_PUSH);
      chk(wa, 16'h01FF);
      chk(wd, f);
      mv = ~f & 8'hEF;
      run(OP_PULLF, CYC_PULL);
      chk(ra, 16'h01FF);
      rd(REG_FLAGS, v);
      chk(v, mv);
      for (int i = 0; i < 24; i++) begin
         rn = nx(rn);
         a = {4'(rn[3:0] % 10), 4'(rn[7:4] % 10)};
         b = {4'(rn[11:8] % 10), 4'(rn[15:12] % 10)};
         if (i < 2) {a, b} = i ? 16'h0001 : 16'h9999;
         if (i < 2) rn[16] = rn[17];
         e = bcd(a, b, rn[16], rn[17]);
         wr(REG_FLAGS, {7'h04, rn[16]});
         wr(REG_ACC, a);
         wr(REG_OPND, b);
         run(rn[17] ? OP_SUB : OP_ADD, CYC_REG);
         rd(REG_ACC, v);
         chk(v, e[7:0]);
         rd(REG_FLAGS, v);
         chk(v & 8'h0D, {7'h04, e[8]});
      end
      rn = nx(rn);
      a = rn[7:0];
      b = rn[15:8] | 8'h01;
      f = (rn[23:16] | 8'h28) & 8'hEF;
      p = 16'(a) * 16'(b);
      wr(REG_FLAGS, f);
      wr(REG_ACC, a);
      wr(REG_OPND, b);
      run(OP_MULT, CYC_MULT);
      rd(REG_HI, v);
      chk(v, p[15:8]);
      rd(REG_ACC, v);
      chk(v, p[7:0]);
      run(OP_QUOT, CYC_QUOT);
      rd(REG_ACC, v);
      chk(v, a);
      rd(REG_HI, v);
      chk(v, 8'h00);
      rd(REG_FLAGS, v);
      chk(v, f);
      for (int o = 1; o < 16; o++) begin
         rn = nx(rn);
         mv = rn[7:0];
         b = rn[15:8];
         t = o < 6 ? {8'h00, rn[23:16]} : {b, rn[31:24]};
         wr(REG_FLAGS, o < 3 ? 8'h20 : o < 6 ? 8'h28 : 8'h08);
         wr(REG_X, rn[23:16]);
         wr(REG_TADDR_L, rn[31:24]);
         wr(REG_TADDR_H, b);
         wr(REG_OPND, b);
         run(5'(o), CYC_RMW);
         chk(ra, t);
         chk(wa, t);
         chk(wd, rmw(5'(o), mv, b));
      end
      for (int i = 0; i < 6; i++) begin
         rn = nx(rn);
         @(posedge clock);
         irq_req <= rn[7:0];
         irq_en <= i ? rn[15:8] : 8'h00;
         wr(REG_FLAGS, 8'h04);
         run(OP_BREAK, CYC_BRK);
         chk(vec, low(rn[7:0] & (i ? rn[15:8] : 8'h00)));
         chk(nt, 16'(i + 1));
      end
      // Slower system clock: phase of the first enable is free, so a window
      wr(REG_CLKCFG, 8'h01);
      rt = 2;
      run(OP_CSET, CYC_REG);
      wr(REG_CLKCFG, 8'h04);
      rt = 16;
      run(OP_CCLR, CYC_REG);
      rd(REG_FLAGS, v);
      chk(v, 8'h04);
      rd(REG_CLKCFG, v);
      chk(v, 8'h04);
      summarize;
   end
endmodule
`default_nettype wire
